// ---- rtl/window_cmp_pkg.sv ----
// Purpose: shared constants and types for the two-channel window comparator register bank
// Assumes: byte-wide register port, 12-bit conversion results, channels 1 and 2 only
// Notes:   per-channel offset tables are indexed by channel slot 0 (channel 1) and 1 (channel 2)
package window_cmp_pkg;

    // widths
    localparam int RESULT_W     = 12;
    localparam int REG_W        = 8;
    localparam int ADDR_W       = 8;
    localparam int CHAN_CODE_W  = 3;
    localparam int NIBBLE_W     = 4;
    localparam int NIBBLE_POS   = 4;
    localparam int MARGIN_W     = 7;
    localparam int MARGIN_SHIFT = 3;
    localparam int CHAN_NUM     = 2;

    // register offsets
    localparam logic [ADDR_W-1:0] CHAN1_MARGIN_AND_HIGH_NIBBLE_OFS  = 8'h24;
    localparam logic [ADDR_W-1:0] CHAN1_UPPER_HIGH_LIMIT_OFS        = 8'h25;
    localparam logic [ADDR_W-1:0] CHAN1_LOW_NIBBLE_AND_DEBOUNCE_OFS = 8'h26;
    localparam logic [ADDR_W-1:0] CHAN1_UPPER_LOW_LIMIT_OFS         = 8'h27;
    localparam logic [ADDR_W-1:0] CHAN2_MARGIN_AND_HIGH_NIBBLE_OFS  = 8'h28;
    localparam logic [ADDR_W-1:0] CHAN2_UPPER_HIGH_LIMIT_OFS        = 8'h29;
    localparam logic [ADDR_W-1:0] CHAN2_LOW_NIBBLE_AND_DEBOUNCE_OFS = 8'h2A;
    localparam logic [ADDR_W-1:0] CHAN2_UPPER_LOW_LIMIT_OFS         = 8'h2B;

    // per-slot offset tables
    localparam logic [ADDR_W-1:0] MARGIN_OFS [CHAN_NUM] =
        '{CHAN1_MARGIN_AND_HIGH_NIBBLE_OFS, CHAN2_MARGIN_AND_HIGH_NIBBLE_OFS};
    localparam logic [ADDR_W-1:0] HIGH_OFS [CHAN_NUM] =
        '{CHAN1_UPPER_HIGH_LIMIT_OFS, CHAN2_UPPER_HIGH_LIMIT_OFS};
    localparam logic [ADDR_W-1:0] DEBOUNCE_OFS [CHAN_NUM] =
        '{CHAN1_LOW_NIBBLE_AND_DEBOUNCE_OFS, CHAN2_LOW_NIBBLE_AND_DEBOUNCE_OFS};
    localparam logic [ADDR_W-1:0] LOW_OFS [CHAN_NUM] =
        '{CHAN1_UPPER_LOW_LIMIT_OFS, CHAN2_UPPER_LOW_LIMIT_OFS};

    // converter channel code served by each slot
    localparam logic [CHAN_CODE_W-1:0] CHAN_CODE [CHAN_NUM] = '{3'h1, 3'h2};

    // reset values
    localparam logic [REG_W-1:0] MARGIN_RST   = 8'hF0;
    localparam logic [REG_W-1:0] HIGH_RST     = 8'hFF;
    localparam logic [REG_W-1:0] DEBOUNCE_RST = 8'h00;
    localparam logic [REG_W-1:0] LOW_RST      = 8'h00;
    localparam logic [REG_W-1:0] UNMAPPED_RD  = 8'h00;

    // qualification state of one channel
    typedef enum logic {QUAL_IDLE, QUAL_ACTIVE} qual_state_type;

endpackage : window_cmp_pkg

// ---- rtl/event_flag_cell.sv ----
// Purpose: one sticky event flag, set by the monitor, cleared by a host write of one
// Assumes: set and clear are single-cycle pulses on mclk
// Notes:   a set in the clearing cycle wins, so no event is lost
module event_flag_cell (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    output logic      flag_state
);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_state <= 1'b0;
        end else if (set_pulse) begin
            flag_state <= 1'b1;
        end else if (clear_pulse) begin
            flag_state <= 1'b0;
        end
    end

    a_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        flag_state && !clear_pulse |=> flag_state)
        else $error("event flag dropped without a clear");

    a_set_beats_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        set_pulse && clear_pulse |=> flag_state)
        else $error("event lost against a simultaneous clear");

    a_clear_works: assert property (@(posedge mclk) disable iff (!rst_n)
        clear_pulse && !set_pulse |=> !flag_state)
        else $error("write of one did not clear the flag");

    c_flag_cleared: cover property (@(posedge mclk) disable iff (!rst_n)
        flag_state ##1 clear_pulse ##1 !flag_state);

endmodule : event_flag_cell

// ---- rtl/chan_window_monitor.sv ----
// Purpose: window test, hysteresis and consecutive-sample debounce for one channel
// Assumes: sample_valid marks a fresh result of this channel
// Notes:   event_hit is a one-cycle pulse one edge after the qualifying sample
module chan_window_monitor (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        sample_valid,
    input  wire logic [11:0] sample,
    input  wire logic [11:0] high_limit,
    input  wire logic [11:0] low_limit,
    input  wire logic [3:0]  margin_code,
    input  wire logic [3:0]  debounce,
    input  wire logic        region_inside,
    output logic             event_hit
);

    window_cmp_pkg::qual_state_type state_r;
    logic [window_cmp_pkg::MARGIN_W-1:0] margin;
    logic [12:0] r13, h13, l13, m13;
    logic        enter_out, stay_out, enter_in, stay_in, qual;
    logic [3:0]  count_r;

    // margin is the code shifted by three
    assign margin = {3'h0, margin_code} << window_cmp_pkg::MARGIN_SHIFT;
    assign r13    = {1'b0, sample};
    assign h13    = {1'b0, high_limit};
    assign l13    = {1'b0, low_limit};
    assign m13    = {6'h00, margin};

    // margin widens both limits once active
    assign enter_out = (r13 > h13) || (r13 < l13);
    assign stay_out  = (r13 + m13 > h13) || (r13 < l13 + m13);
    assign enter_in  = (r13 > l13) && (r13 < h13);
    assign stay_in   = (r13 + m13 > l13) && (r13 < h13 + m13);

    // region bit picks the alert condition
    always_comb begin
        unique case (state_r)
            window_cmp_pkg::QUAL_IDLE:   qual = region_inside ? enter_in : enter_out;
            window_cmp_pkg::QUAL_ACTIVE: qual = region_inside ? stay_in : stay_out;
        endcase
    end

    // qualification state follows each sample
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= window_cmp_pkg::QUAL_IDLE;
        end else if (sample_valid) begin
            state_r <= qual ? window_cmp_pkg::QUAL_ACTIVE : window_cmp_pkg::QUAL_IDLE;
        end
    end

    // count n+1 consecutive hits, restart on a miss
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_r   <= 4'h0;
            event_hit <= 1'b0;
        end else begin
            event_hit <= sample_valid && qual && (count_r >= debounce);
            if (sample_valid && !qual) begin
                count_r <= 4'h0;
            // count saturates at full scale, so a later rise of the debounce setting still sees the true run length
            end else if (sample_valid && count_r != 4'hF) begin
                count_r <= count_r + 4'h1;
            end
        end
    end

    a_debounce_fires: assert property (@(posedge mclk) disable iff (!rst_n)
        sample_valid && qual && count_r >= debounce |=> event_hit)
        else $error("debounce reached but no event");

    a_no_early_event: assert property (@(posedge mclk) disable iff (!rst_n)
        sample_valid && qual && count_r < debounce |=> !event_hit && count_r == $past(count_r) + 4'h1)
        else $error("event before n+1 samples");

    a_miss_restarts: assert property (@(posedge mclk) disable iff (!rst_n)
        sample_valid && !qual |=> count_r == 4'h0 && !event_hit)
        else $error("failing sample did not restart the count");

    a_margin_holds: assert property (@(posedge mclk) disable iff (!rst_n)
        sample_valid && state_r == window_cmp_pkg::QUAL_ACTIVE && !region_inside
        && (r13 + m13 > h13) |=> state_r == window_cmp_pkg::QUAL_ACTIVE)
        else $error("alert released inside the margin band");

    a_inside_region: assert property (@(posedge mclk) disable iff (!rst_n)
        sample_valid && region_inside && r13 > l13 && r13 < h13 |=> state_r == window_cmp_pkg::QUAL_ACTIVE)
        else $error("inside-window result not qualified");

    a_outside_region: assert property (@(posedge mclk) disable iff (!rst_n)
        sample_valid && !region_inside && r13 > h13 |=> state_r == window_cmp_pkg::QUAL_ACTIVE)
        else $error("result above high limit not qualified");

    c_debounced_event: cover property (@(posedge mclk) disable iff (!rst_n)
        debounce == 4'h2 && event_hit);

endmodule : chan_window_monitor

// ---- rtl/window_comparator_threshold_regs.sv ----
// Purpose: threshold, margin and debounce registers of channels 1 and 2 with their window monitors
// Assumes: the serial-port engine delivers byte register accesses on mclk; converter results
//          arrive on mclk with a channel code; region select and flag clears come from core logic
// Notes:   unmapped addresses read as zero and ignore writes
//
// How it works
// - high limit keeps a 12-bit value whose top byte faces result bits 11:4
// - high limit bottom nibble lives in margin register bits 7-4, faces result bits 3:0
// - low limit bottom nibble lives in debounce register bits 7-4, faces result bits 3:0
// - low limit top byte is stored apart and faces result bits 11:4
// - four-bit margin code shifted left three gives a seven-bit margin on both limits
// - event flag sets after debounce setting plus one consecutive qualifying samples
// - channel 1 resets high top byte to all ones, low fields and debounce to zero
// - channel 2 margin register resets with high nibble ones and margin zero
// - region bit zero alerts outside the window, one alerts inside it
// - event flag holds until the host writes one to its bit
module window_comparator_threshold_regs (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // register port from the serial engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    // converter results
    input  wire logic        conv_valid,
    input  wire logic [2:0]  conv_chan,
    input  wire logic [11:0] conv_result,
    // per-slot controls: bit 0 is channel 1, bit 1 is channel 2
    input  wire logic [1:0]  alert_region_select,
    input  wire logic [1:0]  flag_clear,
    output logic [1:0]       event_flag
);

    logic [7:0]  margin_r   [window_cmp_pkg::CHAN_NUM];
    logic [7:0]  high_r     [window_cmp_pkg::CHAN_NUM];
    logic [7:0]  debounce_r [window_cmp_pkg::CHAN_NUM];
    logic [7:0]  low_r      [window_cmp_pkg::CHAN_NUM];
    logic [11:0] high_limit [window_cmp_pkg::CHAN_NUM];
    logic [11:0] low_limit  [window_cmp_pkg::CHAN_NUM];
    logic [1:0]  hit;
    logic [1:0]  slot_valid;
    logic [7:0]  rdata_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < window_cmp_pkg::CHAN_NUM; gi++) begin : g_chan
            localparam logic [7:0] RST_MARGIN = window_cmp_pkg::MARGIN_RST;

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    margin_r[gi]   <= RST_MARGIN;
                    high_r[gi]     <= window_cmp_pkg::HIGH_RST;
                    debounce_r[gi] <= window_cmp_pkg::DEBOUNCE_RST;
                    low_r[gi]      <= window_cmp_pkg::LOW_RST;
                end else if (reg_wr) begin
                    if (reg_addr == window_cmp_pkg::MARGIN_OFS[gi]) begin
                        margin_r[gi] <= reg_wdata;
                    end
                    if (reg_addr == window_cmp_pkg::HIGH_OFS[gi]) begin
                        high_r[gi] <= reg_wdata;
                    end
                    if (reg_addr == window_cmp_pkg::DEBOUNCE_OFS[gi]) begin
                        debounce_r[gi] <= reg_wdata;
                    end
                    if (reg_addr == window_cmp_pkg::LOW_OFS[gi]) begin
                        low_r[gi] <= reg_wdata;
                    end
                end
            end

            // high limit: top byte over nibble from margin register
            assign high_limit[gi] = {high_r[gi],
                margin_r[gi][window_cmp_pkg::NIBBLE_POS +: window_cmp_pkg::NIBBLE_W]};
            // low limit: separate top byte over nibble from debounce register
            assign low_limit[gi]  = {low_r[gi],
                debounce_r[gi][window_cmp_pkg::NIBBLE_POS +: window_cmp_pkg::NIBBLE_W]};

            // route results of this slot's channel only
            assign slot_valid[gi] = conv_valid && (conv_chan == window_cmp_pkg::CHAN_CODE[gi]);

            chan_window_monitor u_monitor (
                .mclk          (mclk),
                .rst_n         (rst_n),
                .sample_valid  (slot_valid[gi]),
                .sample        (conv_result),
                .high_limit    (high_limit[gi]),
                .low_limit     (low_limit[gi]),
                .margin_code   (margin_r[gi][window_cmp_pkg::NIBBLE_W-1:0]),
                .debounce      (debounce_r[gi][window_cmp_pkg::NIBBLE_W-1:0]),
                .region_inside (alert_region_select[gi]),
                .event_hit     (hit[gi])
            );

            // sticky flag, set wins over clear
            event_flag_cell u_flag (
                .mclk        (mclk),
                .rst_n       (rst_n),
                .set_pulse   (hit[gi]),
                .clear_pulse (flag_clear[gi]),
                .flag_state  (event_flag[gi])
            );
        end
    endgenerate

    // read mux over both slots, zero for unmapped addresses
    always_comb begin
        rdata_nxt = window_cmp_pkg::UNMAPPED_RD;
        for (int i = 0; i < window_cmp_pkg::CHAN_NUM; i++) begin
            if (reg_addr == window_cmp_pkg::MARGIN_OFS[i]) begin
                rdata_nxt = margin_r[i];
            end
            if (reg_addr == window_cmp_pkg::HIGH_OFS[i]) begin
                rdata_nxt = high_r[i];
            end
            if (reg_addr == window_cmp_pkg::DEBOUNCE_OFS[i]) begin
                rdata_nxt = debounce_r[i];
            end
            if (reg_addr == window_cmp_pkg::LOW_OFS[i]) begin
                rdata_nxt = low_r[i];
            end
        end
    end

    // registered read answer, one edge after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    // assertions on the register bank

    a_high_top_write: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_wr && reg_addr == window_cmp_pkg::CHAN1_UPPER_HIGH_LIMIT_OFS
        |=> high_limit[0][11:4] == $past(reg_wdata))
        else $error("channel 1 high top byte not taken from write");

    a_high_nibble_path: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_wr && reg_addr == window_cmp_pkg::CHAN2_MARGIN_AND_HIGH_NIBBLE_OFS
        |=> high_limit[1][3:0] == $past(reg_wdata[7:4]) && high_limit[1][11:4] == $past(high_r[1]))
        else $error("channel 2 high nibble not taken from margin bits 7-4");

    a_low_nibble_path: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_wr && reg_addr == window_cmp_pkg::CHAN1_LOW_NIBBLE_AND_DEBOUNCE_OFS
        |=> low_limit[0][3:0] == $past(reg_wdata[7:4]))
        else $error("channel 1 low nibble not taken from debounce bits 7-4");

    a_low_top_write: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_wr && reg_addr == window_cmp_pkg::CHAN2_UPPER_LOW_LIMIT_OFS
        |=> low_limit[1][11:4] == $past(reg_wdata) && low_limit[1][3:0] == $past(debounce_r[1][7:4]))
        else $error("channel 2 low top byte not taken from write");

    a_chan1_reset: assert property (@(posedge mclk)
        $rose(rst_n) |-> high_r[0] == window_cmp_pkg::HIGH_RST && debounce_r[0] == window_cmp_pkg::DEBOUNCE_RST
        && low_r[0] == window_cmp_pkg::LOW_RST)
        else $error("channel 1 reset values wrong");

    a_chan2_reset: assert property (@(posedge mclk)
        $rose(rst_n) |-> margin_r[1] == window_cmp_pkg::MARGIN_RST)
        else $error("channel 2 margin reset value wrong");

    a_read_answer: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_rd && !reg_wr && reg_addr == window_cmp_pkg::CHAN1_UPPER_HIGH_LIMIT_OFS
        |=> reg_rvalid && reg_rdata == high_r[0])
        else $error("read of channel 1 high top byte wrong");

    a_flag_follows_hit: assert property (@(posedge mclk) disable iff (!rst_n)
        hit[0] |=> event_flag[0])
        else $error("debounced event did not set the flag");

    a_other_chan_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        !slot_valid[0] |=> !hit[0])
        else $error("event without a sample of its channel");

    c_chan1_write: cover property (@(posedge mclk) disable iff (!rst_n)
        reg_wr && reg_addr == window_cmp_pkg::CHAN1_UPPER_LOW_LIMIT_OFS);

    c_chan2_event: cover property (@(posedge mclk) disable iff (!rst_n)
        slot_valid[1] ##[1:20] event_flag[1]);

    c_unmapped_read: cover property (@(posedge mclk) disable iff (!rst_n)
        reg_rd && reg_addr == 8'h2C);

endmodule : window_comparator_threshold_regs

// ---- tb/reg_host_model.sv ----
// Purpose: host side of the byte register port, one access at a time
// Assumes: the device answers a read with reg_rvalid one cycle after the strobe
// Notes:   idle address carries the inverse of the last address, idle data the inverse of the last written byte; random idle gaps model a slow host
module reg_host_model (
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    // quiet port until the first access
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // write strobe held across the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        repeat ($urandom_range(2)) @(negedge mclk);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // read strobe, answer taken while reg_rvalid stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        repeat ($urandom_range(2)) @(negedge mclk);
        @(negedge mclk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge mclk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        // reg_rvalid stands only until the next rising edge
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd

endmodule : reg_host_model

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the two-channel threshold register bank
// Assumes: inputs change on the falling edge; flag visible one edge after the taking edge
// Notes:   a byte-array model of the registers and an integer debounce model give every expectation
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk, rst_n, reg_wr, reg_rd, reg_rvalid, conv_valid;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [2:0]  conv_chan;
    logic [11:0] conv_result;
    logic [1:0]  alert_region_select, flag_clear, event_flag;
    logic [7:0]  regs [8];
    bit          q [2];
    bit          ef [2];
    int          cnt [2];
    int          n_mismatch, num_checks, cyc, s, r;

    window_comparator_threshold_regs window_comparator_threshold_regs_inst (.mclk(mclk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_result(conv_result),
        .alert_region_select(alert_region_select), .flag_clear(flag_clear), .event_flag(event_flag));
    reg_host_model reg_host_model_inst (.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // compare one value, report at once
    function automatic void chk(string nm, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endfunction : chk

    // twelve-bit limit of a slot: k=1 high, k=3 low
    function automatic int lim(int sl, int k);
        return regs[4*sl+k] * 16 + regs[4*sl+k-1] / 16;
    endfunction : lim

    // alert test with margin once qualified
    function automatic bit qualifies(int sl, int v, bit in_mode);
        int hi, lo, m;
        hi = lim(sl, 1);
        lo = lim(sl, 3);
        m  = (regs[4*sl] % 16) * 8;
        if (!in_mode) return q[sl] ? (v + m > hi || v < lo + m) : (v > hi || v < lo);
        return q[sl] ? (v + m > lo && v < hi + m) : (v > lo && v < hi);
    endfunction : qualifies

    task automatic wreg(int a, int d);
        reg_host_model_inst.wr(a[7:0], d[7:0]);
        if (a >= 36 && a <= 43) regs[a-36] = d[7:0];
    endtask : wreg

    task automatic rreg(int a);
        logic [7:0] d;
        logic       v;
        reg_host_model_inst.rd(a[7:0], d, v);
        chk("reg_rvalid", 8'h01, {7'h00, v});
        chk("reg_rdata", (a >= 36 && a <= 43) ? regs[a-36] : 8'h00, d);
    endtask : rreg

    // one result, model update, flag compare after the answer latency
    task automatic sample(int c, int v);
        int sl;
        sl = c - 1;
        @(negedge mclk);
        conv_valid  = 1'b1;
        conv_chan   = c[2:0];
        conv_result = v[11:0];
        @(negedge mclk);
        conv_valid  = 1'b0;
        conv_result = ~v[11:0];
        if (sl == 0 || sl == 1) begin
            if (qualifies(sl, v, alert_region_select[sl])) begin
                q[sl] = 1'b1;
                cnt[sl]++;
                if (cnt[sl] >= regs[4*sl+2] % 16 + 1) ef[sl] = 1'b1;
            end else begin
                q[sl]   = 1'b0;
                cnt[sl] = 0;
            end
        end
        repeat (2) @(negedge mclk);
        chk("event_flag", {6'h00, ef[1], ef[0]}, {6'h00, event_flag});
    endtask : sample

    task automatic clr(logic [1:0] b);
        @(negedge mclk);
        flag_clear = b;
        @(negedge mclk);
        flag_clear = 2'b00;
        if (b[0]) ef[0] = 1'b0;
        if (b[1]) ef[1] = 1'b0;
        @(negedge mclk);
        chk("event_flag", {6'h00, ef[1], ef[0]}, {6'h00, event_flag});
    endtask : clr

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        rst_n = 1'b0;
        conv_valid = 1'b0;
        conv_chan = 3'h0;
        conv_result = 12'h000;
        alert_region_select = 2'b00;
        flag_clear = 2'b00;
        regs = '{8'hF0, 8'hFF, 8'h00, 8'h00, 8'hF0, 8'hFF, 8'h00, 8'h00};
        r = $urandom(62621);
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        for (int a = 35; a <= 44; a++) rreg(a);
        $display("test reset_values done");
        for (int a = 35; a <= 44; a++) wreg(a, $urandom_range(255));
        for (int a = 35; a <= 44; a++) rreg(a);
        $display("test readback done");
        wreg(36, 8'h00);
        wreg(37, 8'h80);
        wreg(38, 8'h03);
        wreg(39, 8'h10);
        repeat (3) sample(1, 12'h900);
        sample(3, 12'h900);
        sample(1, 12'h800);
        repeat (4) sample(1, 12'h900);
        clr(2'b01);
        wreg(36, 8'h02);
        sample(1, 12'h900);
        clr(2'b01);
        sample(1, 12'h7F5);
        $display("test debounce done");
        for (int i = 0; i < 300; i++) begin
            s = $urandom_range(1);
            if (i % 25 == 0) begin
                for (int k = 0; k < 4; k++) wreg(36 + 4 * s + k, $urandom_range(255));
                alert_region_select[s] = 1'($urandom_range(1));
            end
            r = ($urandom_range(1) ? lim(s, 1) : lim(s, 3)) + $urandom_range(40) - 20;
            if ($urandom_range(3) == 0) r = $urandom_range(4095);
            if (r < 0) r = 0;
            if (r > 4095) r = 4095;
            sample($urandom_range(5) == 0 ? 3 : s + 1, r);
            if ($urandom_range(9) == 0) clr(2'($urandom_range(3)));
        end
        $display("test random_window done");
        summarize();
    end

endmodule : testbench
